// >>> hw/mbp_bus_phase.sv
// Purpose: Sequences one multiplexed bus transfer and drives its phase indicators.
// Assumes: The far side latches the address while the strobe is high and answers
//          with a one-cycle acknowledge in the data phase.
// Notes:   Phases are address, turnaround, data; every output is a flip-flop.
//
// Operation
// RULE_01 - In the address phase diagnostic output is high for a cache-miss read.
// RULE_02 - Diagnostic level outside read cycles is meaningless; held low here.
// RULE_03 - In second phase diagnostic output is high for fetch, low for data.
// RULE_04 - Address strobe is high while the shared bus holds the valid address.
// RULE_05 - Far side captures the address with the strobe, using transparent latches.
// RULE_06 - Read release rises only after the device has stopped driving the bus.
// RULE_07 - Memory drives the bus only while read release is high.
// RULE_08 - Read release stays low in writes and while no transfer runs.
// RULE_09 - Diagnostic output shows the miss flag, then the instruction flag.
// RULE_10 - Instruction flag appears in the phase right after the address phase.
`timescale 1ns/1ps
`default_nettype none
module mbp_bus_phase
    import mbp_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Transfer request from the core
    input  wire logic                req_i,
    input  wire logic                req_read_i,
    input  wire logic                req_miss_i,
    input  wire logic                req_instr_i,
    input  wire logic [MBP_AD_W-1:0] req_addr_i,
    input  wire logic [MBP_AD_W-1:0] req_wdata_i,
    output logic                     ready_o,
    output logic                     done_o,
    output logic [MBP_AD_W-1:0]      rdata_o,
    // Multiplexed bus
    input  wire logic [MBP_AD_W-1:0] ad_i,
    output logic [MBP_AD_W-1:0]      ad_o,
    output logic                     ad_oe_n_o,
    input  wire logic                ack_i,
    // Phase indicators
    output logic                     ale_o,
    output logic                     diag_o,
    output logic                     read_bus_release_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mbp_state_t          state;
        logic                read;
        logic                miss;
        logic                instr;
        logic [MBP_AD_W-1:0] wdata;
        logic [MBP_AD_W-1:0] ad;
        logic [MBP_AD_W-1:0] rdata;
        logic                oe_n;
        logic                ale;
        logic                diag;
        logic                release_bus;
        logic                done;
        logic                ready;
    } mbp_regs_t;

    localparam mbp_regs_t REGS_RST = '{
        state: MBP_IDLE, read: MBP_OFF, miss: MBP_OFF, instr: MBP_OFF,
        wdata: MBP_AD_RST, ad: MBP_AD_RST, rdata: MBP_AD_RST,
        oe_n: MBP_FLOAT_N, ale: MBP_OFF, diag: MBP_DIAG_RST,
        release_bus: MBP_OFF, done: MBP_OFF, ready: MBP_ON
    };

    mbp_regs_t  r;
    mbp_regs_t  next_r;
    mbp_diag_if dg ();

    mbp_diag_mux u_diag_mux (
        .dg (dg.mux)
    );

    assign dg.phase = next_r.state;
    assign dg.read  = next_r.read;
    assign dg.miss  = next_r.miss;
    assign dg.instr = next_r.instr;

    // ------------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_r             = r;
        next_r.done        = MBP_OFF;
        next_r.ale         = MBP_OFF;
        next_r.release_bus = MBP_OFF; // [RULE_08]
        next_r.oe_n        = MBP_FLOAT_N;
        unique case (r.state)
            MBP_IDLE: begin
                if (req_i) begin
                    next_r.state = MBP_ADDR;
                    next_r.read  = req_read_i;
                    next_r.miss  = req_miss_i;
                    next_r.instr = req_instr_i;
                    next_r.wdata = req_wdata_i;
                    next_r.ad    = req_addr_i;
                end
            end
            MBP_ADDR: next_r.state = MBP_TURN; // [RULE_10]
            MBP_TURN: next_r.state = MBP_DATA;
            MBP_DATA: begin
                if (ack_i) begin
                    next_r.state = MBP_IDLE;
                    next_r.done  = MBP_ON;
                    if (r.read) begin
                        next_r.rdata = ad_i;
                    end
                end
            end
        endcase
        // Outputs follow the phase being entered so that they leave a flop.
        unique case (next_r.state)
            MBP_ADDR: begin
                next_r.ale  = MBP_ON;      // [RULE_04]
                next_r.oe_n = MBP_DRIVE_N;
            end
            MBP_TURN,
            MBP_DATA: begin
                if (!next_r.read) begin
                    next_r.ad   = next_r.wdata;
                    next_r.oe_n = MBP_DRIVE_N;
                end else if (next_r.state == MBP_DATA) begin
                    next_r.release_bus = MBP_ON; // [RULE_06]
                end
            end
            MBP_IDLE: next_r.oe_n = MBP_FLOAT_N;
        endcase
        next_r.diag  = dg.diag; // [RULE_09]
        next_r.ready = (next_r.state == MBP_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign ready_o            = r.ready;
    assign done_o             = r.done;
    assign rdata_o            = r.rdata;
    assign ad_o               = r.ad;
    assign ad_oe_n_o          = r.oe_n;
    assign ale_o              = r.ale;
    assign diag_o             = r.diag;
    assign read_bus_release_o = r.release_bus;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------------
    // Diagnostic output checks
    // ------------------------------------------------------------------
    miss_in_addr_a: assert property ( // [RULE_01]
        req_i && ready_o && req_read_i |=> ale_o && diag_o == $past(req_miss_i))
        else $error("diag not miss flag in address phase");
    idle_diag_low_a: assert property (ready_o |-> !diag_o) // [RULE_02]
        else $error("diag not low while idle");
    write_diag_low_a: assert property ( // [RULE_02]
        req_i && ready_o && !req_read_i |=> !diag_o ##1 !diag_o)
        else $error("diag not low in write");
    instr_in_turn_a: assert property ( // [RULE_03]
        req_i && ready_o && req_read_i |=> ##1 diag_o == $past(req_instr_i, 2))
        else $error("diag not instr flag");
    diag_sequence_a: assert property ( // [RULE_09]
        req_i && ready_o && req_read_i |=>
        diag_o == $past(req_miss_i) ##1 diag_o == $past(req_instr_i, 2))
        else $error("diag phase order wrong");
    instr_follows_addr_a: assert property ( // [RULE_10]
        $fell(ale_o) |-> !ready_o && !read_bus_release_o && !done_o)
        else $error("turn phase does not follow address");

    // ------------------------------------------------------------------
    // Address strobe checks
    // ------------------------------------------------------------------
    strobe_timing_a: assert property ( // [RULE_04]
        req_i && ready_o |=> ale_o && !ad_oe_n_o && ad_o == $past(req_addr_i) ##1 !ale_o)
        else $error("address strobe wrong");
    strobe_busy_a: assert property (ale_o |-> !ready_o && !ad_oe_n_o) // [RULE_04]
        else $error("strobe without driven address");

    // ------------------------------------------------------------------
    // Read release checks
    // ------------------------------------------------------------------
    release_after_float_a: assert property ( // [RULE_06]
        $rose(read_bus_release_o) |-> ad_oe_n_o && $past(ad_oe_n_o))
        else $error("release while driving");
    release_in_data_a: assert property ( // [RULE_06]
        req_i && ready_o && req_read_i |=>
        !read_bus_release_o ##1 !read_bus_release_o ##1 read_bus_release_o)
        else $error("release not raised in data phase");
    release_ends_done_a: assert property ($fell(read_bus_release_o) |-> done_o) // [RULE_06]
        else $error("release dropped before completion");
    no_release_write_a: assert property ( // [RULE_08]
        req_i && ready_o && !req_read_i |=> !read_bus_release_o [*3])
        else $error("release in write");
    no_release_idle_a: assert property (ready_o |-> !read_bus_release_o) // [RULE_08]
        else $error("release while idle");

    // ------------------------------------------------------------------
    // Scenario coverage
    // ------------------------------------------------------------------
    read_cov_c:  cover property (req_i && ready_o && req_read_i ##4 done_o);
    write_cov_c: cover property (req_i && ready_o && !req_read_i ##4 done_o);
    wait_cov_c:  cover property (read_bus_release_o [*3] ##1 done_o);
    fetch_cov_c: cover property (req_i && ready_o && req_read_i && req_miss_i && req_instr_i
        ##4 done_o);

endmodule : mbp_bus_phase
`default_nettype wire

// >>> common/mbp_pkg.sv
// Purpose: Shared types and constants for the multiplexed bus phase indicators.
// Assumes: One bus clock; all phases last whole clock cycles.
// Notes:   Address and data share one bus of width MBP_AD_W.
package mbp_pkg;

    // ------------------------------------------------------------------
    // Widths and levels
    // ------------------------------------------------------------------
    localparam int   MBP_AD_W     = 32;
    localparam logic MBP_DRIVE_N  = 1'b0;
    localparam logic MBP_FLOAT_N  = 1'b1;
    localparam logic MBP_ON       = 1'b1;
    localparam logic MBP_OFF      = 1'b0;
    localparam logic MBP_DIAG_RST = 1'b0;
    localparam logic [MBP_AD_W-1:0] MBP_AD_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MBP_IDLE = 2'b00,
        MBP_ADDR = 2'b01,
        MBP_TURN = 2'b10,
        MBP_DATA = 2'b11
    } mbp_state_t;

endpackage : mbp_pkg

// >>> common/mbp_diag_if.sv
// Purpose: Carries the next bus phase and reference flags to the diagnostic mux.
// Assumes: Purely combinational exchange inside one clock domain.
// Notes:   The controller registers the returned level itself.
`timescale 1ns/1ps
`default_nettype none
interface mbp_diag_if;
    import mbp_pkg::*;
    mbp_state_t phase;
    logic       read;
    logic       miss;
    logic       instr;
    logic       diag;

    modport ctrl (output phase, output read, output miss, output instr, input diag);
    modport mux  (input phase, input read, input miss, input instr, output diag);
endinterface : mbp_diag_if
`default_nettype wire

// >>> hw/mbp_diag_mux.sv
// Purpose: Selects the level of the time multiplexed diagnostic output.
// Assumes: Phase and flags are the values the controller is about to register.
// Notes:   Outside read cycles the level is meaningless; it is held low.
`timescale 1ns/1ps
`default_nettype none
module mbp_diag_mux
    import mbp_pkg::*;
(
    // Phase and flags in, level out
    mbp_diag_if.mux dg
);

    // ------------------------------------------------------------------
    // Phase multiplexing
    // ------------------------------------------------------------------
    always_comb begin
        dg.diag = MBP_DIAG_RST; // [RULE_02]
        if (dg.read) begin
            unique case (dg.phase)
                MBP_ADDR: dg.diag = dg.miss;  // [RULE_01] [RULE_09]
                MBP_TURN: dg.diag = dg.instr; // [RULE_03] [RULE_09] [RULE_10]
                MBP_IDLE,
                MBP_DATA: dg.diag = MBP_DIAG_RST;
            endcase
        end
    end

endmodule : mbp_diag_mux
`default_nettype wire

// >>> tb/mbp_mem_model.sv
// Purpose: Memory system on the far side of the multiplexed bus.
// Assumes: Acknowledge comes wait_i cycles after the earliest data cycle.
// Notes:   A line nobody drives shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module mbp_mem_model
    import mbp_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Device side
    input  wire logic                ale_i,
    input  wire logic                rel_i,
    input  wire logic                oe_n_i,
    input  wire logic [MBP_AD_W-1:0] dev_i,
    input  wire logic [1:0]          wait_i,
    output logic [MBP_AD_W-1:0]      bus_o,
    output logic                     ack_o
);
    logic [MBP_AD_W-1:0] lat;
    logic [MBP_AD_W-1:0] last;
    logic [2:0]          cnt;

    always_latch begin
        if (ale_i) lat = dev_i;
    end
    always_comb begin
        if (oe_n_i == MBP_DRIVE_N) bus_o = dev_i;
        else if (rel_i) bus_o = lat ^ 32'h5A5A_C3C3;
        else bus_o = ~last;
    end
    always_ff @(posedge clk_i) begin
        last <= bus_o;
        if (!rst_n_i) begin
            cnt   <= 3'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= (cnt == 3'h1);
            if (ale_i) cnt <= {1'b0, wait_i} + 3'h1;
            else if (cnt != 3'h0) cnt <= cnt - 3'h1;
        end
    end
endmodule : mbp_mem_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Random reads and writes with phase indicator checks.
// Assumes: Memory answers with random wait states.
// Notes:   Notes are queued at the request and checked at the strobe.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mbp_pkg::*;
    typedef struct packed {
        logic                rd;
        logic                ms;
        logic                ins;
        logic [MBP_AD_W-1:0] ad;
        logic [MBP_AD_W-1:0] wd;
    } mbp_note_t;
    logic clk_i = 0, rst_n_i = 0, req_i = 0, req_read_i = 0, req_miss_i = 0, req_instr_i = 0;
    logic [MBP_AD_W-1:0] req_addr_i = 0, req_wdata_i = 0, rdata_o, ad_i, ad_o;
    logic ready_o, done_o, ad_oe_n_o, ack_i, ale_o, diag_o, read_bus_release_o, ph = 0;
    logic [1:0]  wait_c = 0;
    logic [31:0] seed = 14869, r;
    int          total_checks = 0, miscompares = 0, k;
    mbp_note_t   q[$], n, cur = '0;

    mbp_bus_phase dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .req_read_i(req_read_i), .req_miss_i(req_miss_i), .req_instr_i(req_instr_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o),
        .ack_i(ack_i), .ale_o(ale_o), .diag_o(diag_o), .read_bus_release_o(read_bus_release_o));
    mbp_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .ale_i(ale_o),
        .rel_i(read_bus_release_o), .oe_n_i(ad_oe_n_o), .dev_i(ad_o), .wait_i(wait_c),
        .bus_o(ad_i), .ack_o(ack_i));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        miscompares++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // Driver
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk("release_rst", 32'h0, {31'h0, read_bus_release_o});
        for (int i = 0; i < 200; i++) begin
            r = xs();
            n = '{rd: r[0], ms: r[1], ins: r[2], ad: xs(), wd: xs()};
            req_i       <= 1'b1;
            req_read_i  <= n.rd;
            req_miss_i  <= n.ms;
            req_instr_i <= n.ins;
            req_addr_i  <= n.ad;
            req_wdata_i <= n.wd;
            wait_c      <= r[4:3];
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (ready_o !== 1'b1 && k < 50);
            if (ready_o !== 1'b1) miscompares++;
            q.push_back(n);
        end
        req_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        end_sim();
    end
    // ------------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_n_i === 1'b1 && ale_o === 1'b1 && q.size() > 0) begin
            cur = q.pop_front();
            chk("ad_o", cur.ad, ad_o);
            chk("diag_miss", {31'h0, cur.rd & cur.ms}, {31'h0, diag_o});
            ph = 1'b1;
        end else if (ph) begin
            if (cur.rd) chk("diag_instr", {31'h0, cur.ins}, {31'h0, diag_o});
            if (!cur.rd) chk("ad_wdata", cur.wd, ad_o);
            if (!cur.rd) chk("oe_n_write", {31'h0, MBP_DRIVE_N}, {31'h0, ad_oe_n_o});
            ph = 1'b0;
        end
        if (read_bus_release_o === 1'b1) begin
            chk("oe_n_rel", {31'h0, MBP_FLOAT_N}, {31'h0, ad_oe_n_o});
            chk("rel_kind", 32'h1, {31'h0, cur.rd});
        end
        if (done_o === 1'b1 && cur.rd) chk("rdata_o", cur.ad ^ 32'h5A5A_C3C3, rdata_o);
    end
endmodule : tb
`default_nettype wire
